// file: core/spm_pkg.sv
// Package of constants and carrier types for the SDRAM pattern machine.
package spm_pkg;

    // Register byte offsets on the APB side.
    localparam logic [7:0] OFS_MODE_A   = 8'h00;
    localparam logic [7:0] OFS_MODE_B   = 8'h04;
    localparam logic [7:0] OFS_MODE_C   = 8'h08;
    localparam logic [7:0] OFS_DATA     = 8'h0C;
    localparam logic [7:0] OFS_ADDR     = 8'h10;
    localparam logic [7:0] OFS_PERIOD   = 8'h14;
    localparam logic [7:0] OFS_BANK     = 8'h18;
    localparam logic [7:0] OFS_STATUS   = 8'h1C;

    // Mode register field positions.
    localparam int MODE_REFRESH_ENABLE_BIT_BIT  = 0;
    localparam int MODE_OP_LSB    = 4;
    localparam int MODE_IDX_LSB   = 8;

    // Pattern word field positions (bit 0 is the least significant).
    localparam int WORD_LAST_BIT  = 0;
    localparam int WORD_ACK_BIT   = 2;
    localparam int WORD_REP_LSB   = 8;
    localparam int WORD_CTRL_LSB  = 10;

    // Routine entry points in the pattern arrays; refresh reads only machine A's.
    localparam logic [5:0] BURST_WRITE_BASE = 6'h20;
    localparam logic [5:0] REFRESH_BASE     = 6'h30;

    // Operation select codes.
    localparam logic [1:0] OP_NORMAL = 2'h0;
    localparam logic [1:0] OP_WRITE  = 2'h1;
    localparam logic [1:0] OP_READ   = 2'h2;
    localparam logic [1:0] OP_RUN    = 2'h3;

    // Recommended pattern words.
    localparam logic [31:0] WORD_ACTIVATE = 32'h0F0C_F000;
    localparam logic [31:0] WORD_TRCD_NOP = 32'hFFFF_F100;
    localparam logic [31:0] WORD_WRITE_AUTOPRECHARGE   = 32'h00F3_3C04;
    localparam logic [31:0] WORD_ACK_FOUR = 32'hF0FF_FF04;
    localparam logic [31:0] WORD_ACK_TWO  = 32'hF0FF_FD04;
    localparam logic [31:0] WORD_ACK_LAST = 32'hF0FF_FC05;
    localparam logic [31:0] WORD_REFRESH  = 32'h0FFC_3001;
    localparam logic [31:0] MODE_SET_VAL  = 32'h0000_008C;

    // Reset values.
    localparam logic [15:0] PERIOD_RESET = 16'h0000;
    localparam logic [21:0] CTRL_IDLE    = 22'h3F_FFFF;

    // Timing.
    localparam int CLK_NS  = 50;
    localparam int TRC_NS  = 60;
    localparam int TRC_CYC = (TRC_NS + CLK_NS - 1) / CLK_NS;

    typedef struct packed {
        logic [5:0] word_index;
        logic [1:0] op;
        logic       refresh_enable;
    } spm_mode_type;

    typedef struct packed {
        logic [21:0] ctrl;
        logic        transfer_acknowledge;
        logic [2:0]  bank_sel;
        logic [31:0] addr;
    } spm_sdram_type;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_RUN  = 1'b1
    } spm_fsm_type;

endpackage

// file: core/spm_pattern_machine.sv
// Pattern machine that drives an SDRAM from stored word sequences.
//
// Summary of operation
// RULE1: burst write starts at word 0x20
// RULE2: wait word after activate covers tRCD
// RULE3: word 0x22 writes with precharge, first ack
// RULE4: word 0x23 acknowledges four consecutive cycles
// RULE5: word 0x24 acknowledges exactly two cycles
// RULE6: word 0x25 gives last ack, ends
// RULE7: refresh pattern lives at word 0x30
// RULE8: refresh timer raises refresh service requests
// RULE9: one period register sets every timer
// RULE10: refreshes use machine A pattern, enable
// RULE11: machines B, C refresh only if enabled
// RULE12: refresh word ends pattern, then tRC hold
// RULE13: software may pad refresh with waits
// RULE14: load word via select, data, index, write
// RULE15: mode set uses select 11, address pattern
// RULE16: ack bit drives transfer acknowledge that cycle
// RULE17: end bit finishes pattern after that cycle
// RULE18: repeat count gives value plus one cycles
// RULE19: activate word opens row with select
`timescale 1ns/1ps
module spm_pattern_machine
    import spm_pkg::*;
#(
    parameter int DEPTH = 64
) (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output spm_sdram_type    sdram
);

    typedef struct packed {
        spm_mode_type [2:0] mode;
        logic [31:0]        data_word;
        logic [31:0]        addr_pattern;
        logic [15:0]        period;
        logic [15:0]        timer;
        logic               req_pend;
        logic [1:0]         req_mach;
        logic [1:0]         req_op;
        logic [5:0]         req_index;
        logic               ref_pend;
        spm_fsm_type        fsm;
        logic [1:0]         run_mach;
        logic [5:0]         ptr;
        logic [1:0]         rep;
        logic               is_ref;
        logic               run_addr;
        logic [3:0]         hold;
        logic               pready;
        logic               pslverr;
        logic [31:0]        prdata;
        spm_sdram_type      sdram;
    } spm_state_type;

    localparam logic [3:0] TRC_HOLD = 4'(TRC_CYC);

    spm_state_type state;
    spm_state_type next_state;

    logic [31:0] ram [3][DEPTH];
    logic        ram_we;
    logic [1:0]  ram_mach;
    logic [5:0]  ram_idx;
    logic [31:0] cur_word;
    logic [31:0] sel_word;

    // Machine code 3 has no array; any bank access naming it is refused,
    // so the out-of-range read below never reaches a register.
    assign cur_word = ram[state.run_mach][state.ptr];
    assign sel_word = ram[pwdata[1:0]][state.mode[pwdata[1:0]].word_index];

    always_comb begin
        logic       ans_go;
        logic       wr_go;
        logic       rd_go;
        logic [1:0] m;
        logic       bank_go;
        logic       last_rep;
        logic       ref_fire;
        ans_go   = 1'b0;
        wr_go    = 1'b0;
        rd_go    = 1'b0;
        m        = 2'h0;
        bank_go  = 1'b0;
        last_rep = 1'b0;
        ref_fire = 1'b0;
        next_state = state;
        ram_we   = 1'b0;
        ram_mach = 2'h0;
        ram_idx  = 6'h00;

        // APB slave answers one cycle into the access phase.
        ans_go = psel && penable && !state.pready;
        next_state.pready  = ans_go;
        next_state.pslverr = 1'b0;
        // A write lands at the edge that samples pready, so a master
        // that aborts before the answer leaves no trace behind.
        wr_go = psel && penable && state.pready && pwrite;
        rd_go = ans_go && !pwrite;
        m     = pwdata[1:0];

        // Write errors are decided here so that they stand together with
        // pready; the write itself follows one edge later.
        if (ans_go && pwrite) begin
            unique case (paddr)
                OFS_MODE_A, OFS_MODE_B, OFS_MODE_C, OFS_DATA, OFS_ADDR,
                OFS_PERIOD: next_state.pslverr = 1'b0;
                OFS_BANK:   next_state.pslverr = m == 2'h3;
                default:    next_state.pslverr = 1'b1;
            endcase
        end

        if (wr_go) begin
            unique case (paddr)
                OFS_MODE_A: next_state.mode[0] = pwdata[14:0] == 15'h0000 ?
                    spm_mode_type'(9'h000) :
                    spm_mode_type'({pwdata[13:8], pwdata[5:4], pwdata[0]});
                OFS_MODE_B: next_state.mode[1] =
                    spm_mode_type'({pwdata[13:8], pwdata[5:4], pwdata[0]});
                OFS_MODE_C: next_state.mode[2] =
                    spm_mode_type'({pwdata[13:8], pwdata[5:4], pwdata[0]});
                OFS_DATA:   next_state.data_word    = pwdata;
                OFS_ADDR:   next_state.addr_pattern = pwdata;
                // RULE9: shared timer period
                OFS_PERIOD: next_state.period = pwdata[15:0];
                OFS_BANK: bank_go = m != 2'h3;
                default:  bank_go = 1'b0;
            endcase
        end

        // RULE14: dummy bank write stores word
        if (bank_go) begin
            unique case (state.mode[m].op)
                OP_WRITE: begin
                    ram_we   = 1'b1;
                    ram_mach = m;
                    ram_idx  = state.mode[m].word_index;
                end
                OP_READ: next_state.data_word = sel_word;
                OP_NORMAL, OP_RUN: begin
                    // A second request while one waits is dropped.
                    if (!state.req_pend) begin
                        next_state.req_pend  = 1'b1;
                        next_state.req_mach  = m;
                        next_state.req_op    = state.mode[m].op;
                        next_state.req_index = state.mode[m].word_index;
                    end
                end
            endcase
        end

        if (rd_go) begin
            unique case (paddr)
                OFS_MODE_A, OFS_MODE_B, OFS_MODE_C: begin
                    next_state.prdata = 32'h0000_0000;
                    next_state.prdata[MODE_IDX_LSB +: 6] =
                        state.mode[paddr[3:2]].word_index;
                    next_state.prdata[MODE_OP_LSB +: 2] =
                        state.mode[paddr[3:2]].op;
                    next_state.prdata[MODE_REFRESH_ENABLE_BIT_BIT] =
                        state.mode[paddr[3:2]].refresh_enable;
                end
                OFS_DATA:   next_state.prdata = state.data_word;
                OFS_ADDR:   next_state.prdata = state.addr_pattern;
                OFS_PERIOD: next_state.prdata = {16'h0000, state.period};
                OFS_BANK:   next_state.prdata = 32'h0000_0000;
                OFS_STATUS: next_state.prdata = {16'h0000, state.ptr,
                    state.run_mach, 4'h0, state.is_ref, state.ref_pend,
                    state.req_pend, state.fsm};
                default: begin
                    next_state.prdata  = 32'h0000_0000;
                    next_state.pslverr = 1'b1;
                end
            endcase
        end

        // RULE8: timer raises refresh requests
        if (state.period == 16'h0000) begin
            next_state.timer = 16'h0000;
        end else if (state.timer == 16'h0000) begin
            next_state.timer = state.period;
            // RULE10: only machine A enable counts
            if (state.mode[0].refresh_enable) begin
                ref_fire = 1'b1;
            end
        end else begin
            next_state.timer = state.timer - 16'h0001;
        end

        // Only the end of a refresh loads the hold; here it just drains.
        if (state.hold != 4'h0) begin
            next_state.hold = state.hold - 4'h1;
        end

        // Pins follow the executing word one cycle late, straight from flops.
        unique case (state.fsm)
            ST_IDLE: begin
                next_state.sdram.ctrl                 = CTRL_IDLE;
                next_state.sdram.transfer_acknowledge = 1'b0;
                next_state.sdram.bank_sel             = 3'h0;
                next_state.sdram.addr                 = 32'h0000_0000;
                if (state.hold == 4'h0 && state.ref_pend) begin
                    // Refresh wins so that rows never lose their charge.
                    next_state.ref_pend = 1'b0;
                    next_state.fsm      = ST_RUN;
                    next_state.is_ref   = 1'b1;
                    next_state.run_mach = 2'h0;
                    next_state.run_addr = 1'b0;
                    next_state.rep      = 2'h0;
                    // RULE7: refresh entry point
                    next_state.ptr      = REFRESH_BASE;
                end else if (state.hold == 4'h0 && state.req_pend) begin
                    next_state.req_pend = 1'b0;
                    next_state.fsm      = ST_RUN;
                    next_state.is_ref   = 1'b0;
                    next_state.run_mach = state.req_mach;
                    next_state.run_addr = state.req_op == OP_RUN;
                    next_state.rep      = 2'h0;
                    // RULE1: burst write entry point
                    next_state.ptr = state.req_op == OP_RUN ?
                        state.req_index : BURST_WRITE_BASE;
                end
            end
            ST_RUN: begin
                // RULE19: word lines drive select and row
                next_state.sdram.ctrl = cur_word[31:WORD_CTRL_LSB];
                // RULE3: write word gives first ack
                // RULE4: four-repeat word acks each cycle
                // RULE5: two-repeat word acks twice
                // RULE16: acknowledge follows the word bit
                next_state.sdram.transfer_acknowledge =
                    cur_word[WORD_ACK_BIT];
                // RULE11: refresh reaches enabled machines
                if (state.is_ref) begin
                    next_state.sdram.bank_sel = {state.mode[2].refresh_enable,
                        state.mode[1].refresh_enable, 1'b1};
                end else begin
                    next_state.sdram.bank_sel = 3'(3'h1 << state.run_mach);
                end
                // RULE15: mode set presents address pattern
                // The run keeps its own copy of the operation, since a
                // request queued meanwhile overwrites the stored req_op.
                next_state.sdram.addr = state.run_addr ?
                    state.addr_pattern : 32'h0000_0000;
                // RULE2: repeats stretch the tRCD wait
                // RULE18: repeat count plus one cycles
                last_rep = state.rep == cur_word[WORD_REP_LSB +: 2];
                if (!last_rep) begin
                    next_state.rep = state.rep + 2'h1;
                end else if (cur_word[WORD_LAST_BIT]) begin
                    // RULE6: last ack ends the burst
                    // RULE17: end bit closes the service
                    next_state.fsm = ST_IDLE;
                    next_state.rep = 2'h0;
                    // RULE12: hold off commands for tRC
                    next_state.hold = state.is_ref ? TRC_HOLD : 4'h0;
                end else begin
                    next_state.rep = 2'h0;
                    next_state.ptr = state.ptr + 6'h01;
                end
            end
        endcase

        // A timer tick in the start cycle is kept: set wins over clear.
        if (ref_fire) begin
            next_state.ref_pend = 1'b1;
        end
    end

    // The pattern arrays hold no reset so they map onto plain memory.
    always_ff @(posedge core_clk) begin
        if (ram_we) begin
            ram[ram_mach][ram_idx] <= state.data_word;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state        <= '0;
            state.period <= PERIOD_RESET;
            state.fsm    <= ST_IDLE;
            state.sdram.ctrl <= CTRL_IDLE;
        end else begin
            state <= next_state;
        end
    end

    assign prdata  = state.prdata;
    assign pready  = state.pready;
    assign pslverr = state.pslverr;
    assign sdram   = state.sdram;

endmodule // spm_pattern_machine

// file: verif/spm_sdram_model.sv
// Behavioural SDRAM that tallies the commands the pattern machine sends.
`timescale 1ns/1ps
module spm_sdram_model
    import spm_pkg::*;
(
    input  wire logic          core_clk,
    input  wire logic          rst_b,
    input  wire spm_sdram_type sdram,
    output int                 ack_count,
    output int                 ref_count,
    output logic [2:0]         ref_banks,
    output logic [31:0]        mode_value
);
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_count  <= 0;
            ref_count  <= 0;
            ref_banks  <= 3'h0;
            mode_value <= 32'h0000_0000;
        end else begin
            if (sdram.transfer_acknowledge === 1'b1) begin
                ack_count <= ack_count + 1;
            end
            if (sdram.ctrl === WORD_REFRESH[31:10]) begin
                ref_count <= ref_count + 1;
                ref_banks <= sdram.bank_sel;
            end
            if (sdram.addr !== 32'h0000_0000) begin
                mode_value <= sdram.addr;
            end
        end
    end
endmodule // spm_sdram_model

// file: verif/spm_pattern_machine_chk.sv
// Port assertions for the SDRAM pattern machine.
`timescale 1ns/1ps
module spm_pattern_machine_chk
    import spm_pkg::*;
(
    input  wire logic          core_clk,
    input  wire logic          rst_b,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic [7:0]    paddr,
    input  wire logic          pready,
    input  wire logic          pslverr,
    input  wire spm_sdram_type sdram
);
    localparam logic [21:0] C_ACT = WORD_ACTIVATE[31:10];
    localparam logic [21:0] C_NOP = WORD_TRCD_NOP[31:10];
    localparam logic [21:0] C_WRA = WORD_WRITE_AUTOPRECHARGE[31:10];
    localparam logic [21:0] C_ACK = WORD_ACK_FOUR[31:10];
    localparam logic [21:0] C_REF = WORD_REFRESH[31:10];
    logic [21:0] c;
    logic        ak;
    assign c  = sdram.ctrl;
    assign ak = sdram.transfer_acknowledge;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence s_act;  c == C_ACT && !ak; endsequence
    sequence s_wait; (c == C_NOP && !ak) [*2]; endsequence
    sequence s_wra;  c == C_WRA && ak; endsequence
    sequence s_acks; (c == C_ACK && ak) [*7]; endsequence
    AST_APB_WAIT: assert property (psel && penable && !pready |=> pready)
        else $error("no answer one cycle into the access phase");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("ready stood longer than one cycle");
    AST_ERR_UNMAPPED: assert property (psel && penable && !pready
        && paddr > 8'h1C |=> pready && pslverr)
        else $error("unmapped access not refused");
    AST_ACTIVATE: assert property ($rose(c == C_ACT)
        |-> s_act ##1 s_wait ##1 s_wra)
        else $error("activate, wait, write order broken");
    AST_BURST: assert property ($rose(c == C_WRA)
        |-> s_wra ##1 s_acks ##1 c == CTRL_IDLE)
        else $error("burst write did not give eight acks and end");
    AST_ACK_BIT: assert property (c == C_ACT || c == C_NOP || c == C_REF
        |-> !ak)
        else $error("ack raised by a word without its ack bit");
    AST_REFRESH: assert property ($rose(c == C_REF)
        |-> c == C_REF ##1 (c == CTRL_IDLE) [*2])
        else $error("refresh not one cycle followed by idle");
    AST_REFRESH_BANK: assert property (c == C_REF |-> sdram.bank_sel[0])
        else $error("refresh left out the first machine banks");
    AST_BURST_ADDR: assert property (c == C_WRA |-> sdram.addr == '0)
        else $error("burst drove the mode address");
endmodule // spm_pattern_machine_chk
bind spm_pattern_machine spm_pattern_machine_chk i_spm_pattern_machine_chk (
    .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .paddr(paddr), .pready(pready), .pslverr(pslverr), .sdram(sdram));

// file: verif/testbench.sv
// Self-checking bench for the SDRAM pattern machine.
`timescale 1ns/1ps
module testbench
    import spm_pkg::*;
;
    logic core_clk, rst_b, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q, r;
    logic [5:0] idx;
    logic [2:0] ref_banks;
    logic [31:0] mode_value;
    spm_sdram_type sdram;
    int ack_count, ref_count, errors, comparisons, seed, n, a0;
    logic [31:0] bw [6] = '{WORD_ACTIVATE, WORD_TRCD_NOP, WORD_WRITE_AUTOPRECHARGE,
                           WORD_ACK_FOUR, WORD_ACK_TWO, WORD_ACK_LAST};
    spm_pattern_machine i_spm_pattern_machine (.core_clk(core_clk),
        .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sdram(sdram));
    spm_sdram_model i_spm_sdram_model (.core_clk(core_clk), .rst_b(rst_b),
        .sdram(sdram), .ack_count(ack_count), .ref_count(ref_count),
        .ref_banks(ref_banks), .mode_value(mode_value));
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    function automatic logic [31:0] mw(logic [1:0] op, logic [5:0] i, logic en);
        return {18'h0, i, 2'h0, op, 3'h0, en};
    endfunction
    // Acks per word are the repeat count plus one when the ack bit is set.
    function automatic int exp_acks();
        int s = 0;
        foreach (bw[k]) if (bw[k][WORD_ACK_BIT]) s += bw[k][9:8] + 1;
        return s;
    endfunction
    task automatic print_verdict();
        if (errors == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic guard(input int lim);
        if (n >= lim) begin
            errors++;
            $display("ERROR %0t: wait ran out", $time);
            print_verdict();
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        guard(20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic load(input logic [7:0] m, input logic [5:0] i, input logic [31:0] w);
        apb(1'b1, OFS_MODE_A + 8'(4 * m), mw(OP_WRITE, i, 1'b0));
        apb(1'b1, OFS_DATA, w);
        apb(1'b1, OFS_BANK, {24'h0, m});
    endtask
    task automatic idle(input int k);
        repeat (k) @(posedge core_clk);
    endtask
    initial begin
        seed = 42312;
        errors = 0;
        comparisons = 0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        rst_b = 1'b0;
        idle(12);
        rst_b <= 1'b1;
        @(posedge core_clk);
        apb(1'b0, OFS_PERIOD, 32'h0);
        chk(q, {16'h0, PERIOD_RESET});
        chk({31'h0, e}, 32'h0);
        r = $random(seed);
        apb(1'b1, OFS_ADDR, r);
        apb(1'b0, OFS_ADDR, 32'h0);
        chk(q, r);
        apb(1'b0, 8'h24, 32'h0);
        chk({q[30:0], e}, 32'h0000_0001);
        apb(1'b1, OFS_BANK, 32'h3);
        chk({31'h0, e}, 32'h1);
        foreach (bw[k]) load(8'h0, BURST_WRITE_BASE + 6'(k), bw[k]);
        load(8'h0, REFRESH_BASE, WORD_REFRESH);
        // Random words on machine B; data register is spoiled before reading.
        repeat (4) begin
            idx = 6'($random(seed));
            r = $random(seed);
            load(8'h1, idx, r);
            apb(1'b1, OFS_DATA, ~r);
            apb(1'b1, OFS_MODE_B, mw(OP_READ, idx, 1'b0));
            apb(1'b1, OFS_BANK, 32'h1);
            apb(1'b0, OFS_DATA, 32'h0);
            chk(q, r);
            apb(1'b0, OFS_MODE_B, 32'h0);
            chk(q, mw(OP_READ, idx, 1'b0));
        end
        apb(1'b1, OFS_MODE_A, mw(OP_NORMAL, 6'h0, 1'b0));
        repeat (2) begin
            a0 = ack_count;
            apb(1'b1, OFS_BANK, 32'h0);
            for (n = 0; n < 40 && ack_count < a0 + exp_acks(); n++) idle(1);
            guard(40);
            idle(4);
            chk(32'(ack_count - a0), 32'h0000_0008);
            apb(1'b0, OFS_STATUS, 32'h0);
            chk({29'h0, q[2:0]}, 32'h0);
        end
        load(8'h0, 6'h36, 32'h00A0_3C31);
        apb(1'b1, OFS_MODE_A, mw(OP_RUN, 6'h36, 1'b0));
        apb(1'b1, OFS_ADDR, MODE_SET_VAL);
        apb(1'b1, OFS_BANK, 32'h0);
        for (n = 0; n < 30 && mode_value !== MODE_SET_VAL; n++) idle(1);
        guard(30);
        chk(mode_value, MODE_SET_VAL);
        apb(1'b1, OFS_MODE_A, mw(OP_NORMAL, 6'h0, 1'b1));
        apb(1'b1, OFS_MODE_B, mw(OP_NORMAL, 6'h0, 1'b1));
        a0 = ref_count;
        apb(1'b1, OFS_PERIOD, 32'h0000_0014);
        idle(200);
        chk({29'h0, ref_banks}, 32'h0000_0003);
        chk(32'(ref_count - a0 >= 8 && ref_count - a0 <= 10), 32'h1);
        apb(1'b1, OFS_MODE_B, mw(OP_NORMAL, 6'h0, 1'b0));
        idle(60);
        chk({29'h0, ref_banks}, 32'h0000_0001);
        apb(1'b1, OFS_MODE_C, mw(OP_NORMAL, 6'h0, 1'b1));
        idle(60);
        chk({29'h0, ref_banks}, 32'h0000_0005);
        apb(1'b1, OFS_MODE_A, mw(OP_NORMAL, 6'h0, 1'b0));
        idle(30);
        a0 = ref_count;
        idle(100);
        chk(32'(ref_count - a0), 32'h0);
        print_verdict();
    end
endmodule // testbench
